// >>> verilog/halfduplex_suppression_control.sv
// Operation
// - rx speech when rx power beats rx noise by selected threshold
// - rx suppression released above release threshold, until speech ends
// - release threshold never affects residual echo attenuation
// - noise estimates rise at selected rate up to input power
// - noise estimates follow falling input power at once
// - after a channel idles, ownership change blocked for holdover delay
// - howl with hold bit set keeps half-duplex until bit clears
// - howl with hold bit clear drops, retrains, returns to full-duplex
// - tx double-talk attenuation inserted with about 42 ms attack
// - tx decay select: 0 slow about 1 s, 1 about 84 ms
// - rx double-talk attenuation, about 18 ms attack, decay chosen by bit 5
// - idle return bit moves idle state into transmit
// - idle entered after active channel silent for holdover delay
// - every field resets to encoding zero
`timescale 1ns/1ps
`include "hdsc_regs.svh"
module halfduplex_suppression_control #(
   parameter int TICK_CYCLES = `TICK_NS / `CLK_NS
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rstn,
   // register port
   input  wire logic [3:0]          addr,
   input  wire logic [15:0]         wdata,
   input  wire logic                wrStb,
   input  wire logic                rdStb,
   output logic      [15:0]         rdata,
   // power and activity
   input  wire hdsc_pkg::pwr_t      rxPower,
   input  wire hdsc_pkg::pwr_t      txPower,
   input  wire logic                txSpeech,
   input  wire logic                rxEchoResidual,
   input  wire logic                doubleTalk,
   input  wire logic [2:0]          txDtAtt,
   input  wire logic [1:0]          rxDtAtt,
   // duplex control
   input  wire logic                howlDetect,
   input  wire logic                retrainDone,
   // status
   output logic                     rxSpeech,
   output logic                     rxSuppress,
   output hdsc_pkg::hd_state_t      hdState,
   output logic                     fullDuplex,
   output hdsc_pkg::att_t           txAtt,
   output hdsc_pkg::att_t           rxAtt,
   output hdsc_pkg::pwr_t           rxNoise,
   output hdsc_pkg::pwr_t           txNoise
);
   logic [15:0]         ctrl;
   logic [17:0]         tickCount;
   logic                tick;
   logic [7:0]          holdCount;
   logic                ownerTx;
   logic                txHeard;
   logic                released;
   logic                howlPending;
   logic [2:0]          slowCount;
   hdsc_pkg::hd_state_t next_state;

   noise_if rxNif ();
   noise_if txNif ();

   // field decode
   wire        hit       = (addr == `HDSC_ADDR);
   wire        regWrite  = wrStb && hit && (wdata[3:0] == `HDSC_SEL);
   wire [1:0]  rx_speech_detect_threshold     = ctrl[`RX_SPEECH_DETECT_THRESHOLD_LSB +: 2];
   wire [1:0]  rx_suppression_release_threshold     = ctrl[`RX_SUPPRESSION_RELEASE_THRESHOLD_LSB +: 2];
   wire [1:0]  riseSel   = ctrl[`RISE_LSB +: 2];
   wire [1:0]  holdSel   = ctrl[`HOLD_LSB +: 2];
   wire        howlHold  = ctrl[`HOWL_BIT];
   wire        txDecNorm = ctrl[`TXDEC_BIT];
   wire        rxDecNorm = ctrl[`RXDEC_BIT];
   wire        idleTx    = ctrl[`IDLETX_BIT];
   wire [7:0]  holdLimit = (holdSel == 2'b00) ? `HOLD_MS_200 :
                           (holdSel == 2'b01) ? `HOLD_MS_100 : `HOLD_MS_150;
   wire        holdDone  = tick && (holdCount >= holdLimit - 8'd1);
   wire        slowDue   = (slowCount == `SLOW_MS - 3'd1);
   wire        ownerTalk = ownerTx ? txSpeech : rxSpeech;

   // threshold in 1/8 dB, reserved code read as the largest
   function automatic logic [10:0] thrOf(input logic [1:0] sel);
      logic [10:0] t;
      t = (sel == 2'b00) ? `THR_6DB : (sel == 2'b01) ? `THR_9DB : `THR_12DB;
      return t;
   endfunction

   function automatic logic above(input hdsc_pkg::pwr_t p,
                                  input hdsc_pkg::pwr_t n,
                                  input logic [1:0]     sel);
      logic [10:0] lim;
      lim = {1'b0, n} + thrOf(sel);
      return {1'b0, p} > lim;
   endfunction

   // one ramp step toward target
   function automatic hdsc_pkg::att_t ramp(input hdsc_pkg::att_t cur,
                                           input hdsc_pkg::att_t tgt,
                                           input logic           normal,
                                           input logic           due);
      hdsc_pkg::att_t step;
      step = normal ? `NORMAL_STEP : (due ? 8'd1 : 8'd0);
      if (cur < tgt)
         return (tgt - cur > `ATTACK_STEP) ? cur + `ATTACK_STEP : tgt;
      else if (cur > tgt)
         return (cur - tgt > step) ? cur - step : tgt;
      else
         return cur;
   endfunction

   wire        rsExceed  = above(rxPower, rxNoise, rx_suppression_release_threshold);
   wire [7:0]  txTarget  = doubleTalk ? 8'(txDtAtt * `DB3_LSB) : 8'd0;
   wire [7:0]  rxTarget  = doubleTalk ? 8'(rxDtAtt * `DB3_LSB) : 8'd0;

   // noise trackers
   assign rxNif.power = rxPower;
   assign rxNif.rate  = riseSel;
   assign rxNif.tick  = tick;
   assign txNif.power = txPower;
   assign txNif.rate  = riseSel;
   assign txNif.tick  = tick;

   noise_floor_tracker rxTrack (
      .clk  (clk),
      .rstn (rstn),
      .nif  (rxNif.tracker)
   );

   noise_floor_tracker txTrack (
      .clk  (clk),
      .rstn (rstn),
      .nif  (txNif.tracker)
   );

   assign rxNoise = rxNif.noise;
   assign txNoise = txNif.noise;

   // millisecond tick
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tickCount <= '0;
         tick      <= 1'b0;
      end
      else
      begin
         tick      <= (tickCount == 18'(TICK_CYCLES - 1));
         tickCount <= (tickCount == 18'(TICK_CYCLES - 1)) ? 18'd0 : tickCount + 18'd1;
      end
   end

   // reset fields to zero (register reads 0004), write only when selected
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         ctrl <= `HDSC_RESET;
      else if (regWrite)
         ctrl <= (wdata & `HDSC_WMASK) | {12'h000, `HDSC_SEL};
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rdata <= '0;
      else
         rdata <= (rdStb && hit) ? ctrl : 16'h0000;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rxSpeech <= 1'b0;
      else
         rxSpeech <= above(rxPower, rxNoise, rx_speech_detect_threshold);
   end

   // release latch, echo path kept apart
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         released   <= 1'b0;
         rxSuppress <= 1'b1;
      end
      else
      begin
         released   <= rsExceed || (released && rxSpeech);
         rxSuppress <= !(rsExceed || (released && rxSpeech)) || rxEchoResidual;
      end
   end

   always_comb
   begin
      next_state = hdState;
      unique case (hdState)
         hdsc_pkg::HD_IDLE:
            if (rxSpeech)
               next_state = hdsc_pkg::HD_RX;
            else if (txSpeech || idleTx)
               next_state = hdsc_pkg::HD_TX;
         hdsc_pkg::HD_TX:
            if (txHeard && !txSpeech)
               next_state = hdsc_pkg::HD_HOLD;
            else if (!txHeard && !txSpeech && rxSpeech)
               next_state = hdsc_pkg::HD_RX;
         hdsc_pkg::HD_RX:
            if (!rxSpeech)
               next_state = hdsc_pkg::HD_HOLD;
         hdsc_pkg::HD_HOLD:
            if (ownerTalk)
               next_state = ownerTx ? hdsc_pkg::HD_TX : hdsc_pkg::HD_RX;
            else if (holdDone)
               next_state = hdsc_pkg::HD_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         hdState   <= hdsc_pkg::HD_IDLE;
         ownerTx   <= 1'b0;
         txHeard   <= 1'b0;
         holdCount <= '0;
      end
      else
      begin
         hdState <= next_state;
         txHeard <= (next_state == hdsc_pkg::HD_TX) && (txHeard || txSpeech);
         if (hdState != hdsc_pkg::HD_HOLD)
            ownerTx <= (hdState == hdsc_pkg::HD_TX);
         if (hdState != hdsc_pkg::HD_HOLD || ownerTalk)
            holdCount <= '0;
         else if (tick)
            holdCount <= holdCount + 8'd1;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         fullDuplex  <= 1'b0;
         howlPending <= 1'b0;
      end
      else if (howlDetect)
      begin
         fullDuplex  <= 1'b0;
         howlPending <= 1'b1;
      end
      else if (!fullDuplex && retrainDone && !(howlPending && howlHold))
      begin
         fullDuplex  <= 1'b1;
         howlPending <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         txAtt     <= '0;
         rxAtt     <= '0;
         slowCount <= '0;
      end
      else if (tick)
      begin
         slowCount <= slowDue ? 3'd0 : slowCount + 3'd1;
         txAtt     <= ramp(txAtt, txTarget, txDecNorm, slowDue);
         rxAtt     <= ramp(rxAtt, rxTarget, rxDecNorm, slowDue);
      end
   end

   // checks
   sequence howlThenRetrain;
      howlDetect ##1 (!howlDetect && retrainDone && !howlHold)[*2];
   endsequence

   sequence holdExpire;
      hdState == hdsc_pkg::HD_HOLD ##1 hdState == hdsc_pkg::HD_IDLE;
   endsequence

   chk_rx_speech_thr: assert property (
      @(posedge clk) disable iff (!rstn)
      (above(rxPower, rxNoise, rx_speech_detect_threshold) && !regWrite)[*2] |-> rxSpeech)
      else $error("rx speech not declared above threshold");

   chk_release_keep: assert property (
      @(posedge clk) disable iff (!rstn)
      rsExceed ##1 (rxSpeech && !rxEchoResidual) |=> !rxSuppress)
      else $error("rx suppression reinserted during speech");

   chk_echo_atten: assert property (
      @(posedge clk) disable iff (!rstn)
      rxEchoResidual |=> rxSuppress)
      else $error("residual echo not attenuated");

   chk_hold_owner: assert property (
      @(posedge clk) disable iff (!rstn)
      hdState == hdsc_pkg::HD_HOLD |=>
      hdState != (ownerTx ? hdsc_pkg::HD_RX : hdsc_pkg::HD_TX))
      else $error("ownership changed during holdover");

   chk_idle_entry: assert property (
      @(posedge clk) disable iff (!rstn)
      holdExpire |-> $past(holdCount) >= holdLimit - 8'd1 && $past(tick))
      else $error("idle entered before holdover end");

   chk_idle_to_tx: assert property (
      @(posedge clk) disable iff (!rstn)
      hdState == hdsc_pkg::HD_IDLE && idleTx && !rxSpeech |=> hdState == hdsc_pkg::HD_TX)
      else $error("idle did not return to transmit");

   chk_howl_keep: assert property (
      @(posedge clk) disable iff (!rstn)
      howlPending && howlHold && !fullDuplex |=> !fullDuplex)
      else $error("left half-duplex while howl hold set");

   chk_howl_return: assert property (
      @(posedge clk) disable iff (!rstn)
      howlThenRetrain |-> fullDuplex)
      else $error("no return to full-duplex after retrain");

   chk_tx_attack: assert property (
      @(posedge clk) disable iff (!rstn)
      txAtt > $past(txAtt) |->
      (txAtt - $past(txAtt) <= `ATTACK_STEP) && $past(doubleTalk))
      else $error("tx attack step too large");

   chk_tx_slow_decay: assert property (
      @(posedge clk) disable iff (!rstn)
      !txDecNorm && txAtt < $past(txAtt) |-> $past(txAtt) - txAtt == 8'd1)
      else $error("tx slow decay step wrong");

   chk_rx_decay: assert property (
      @(posedge clk) disable iff (!rstn)
      rxDecNorm && rxAtt < $past(rxAtt) |-> $past(rxAtt) - rxAtt <= `NORMAL_STEP)
      else $error("rx decay step wrong");

   chk_reg_select: assert property (
      @(posedge clk) disable iff (!rstn)
      wrStb && hit && wdata[3:0] != `HDSC_SEL |=> ctrl == $past(ctrl))
      else $error("unselected write changed the register");
endmodule

// >>> verilog/hdsc_regs.svh
`ifndef HDSC_REGS_SVH
`define HDSC_REGS_SVH

// register access
`define HDSC_ADDR       4'h2
`define HDSC_SEL        4'h4
`define HDSC_RESET      16'h0004
`define HDSC_WMASK      16'hfff0

// field positions
`define RX_SPEECH_DETECT_THRESHOLD_LSB       14
`define RX_SUPPRESSION_RELEASE_THRESHOLD_LSB       12
`define RISE_LSB        10
`define HOLD_LSB        8
`define HOWL_BIT        7
`define TXDEC_BIT       6
`define RXDEC_BIT       5
`define IDLETX_BIT      4

// power scale is 1/8 dB per lsb
`define THR_6DB         11'd48
`define THR_9DB         11'd72
`define THR_12DB        11'd96
`define DB3_LSB         8'd24

// timing
`define CLK_NS          4
`define TICK_NS         1000000
`define RISE_MS_3DB     6'd42
`define RISE_MS_6DB     6'd21
`define RISE_MS_12DB    6'd10
`define HOLD_MS_200     8'd200
`define HOLD_MS_100     8'd100
`define HOLD_MS_150     8'd150
`define ATTACK_STEP     8'd4
`define NORMAL_STEP     8'd2
`define SLOW_MS         3'd6

`endif

// >>> verilog/hdsc_pkg.sv
package hdsc_pkg;
   typedef logic [9:0] pwr_t;
   typedef logic [7:0] att_t;
   typedef enum logic [1:0]
   {
      HD_IDLE = 2'b00,
      HD_TX   = 2'b01,
      HD_HOLD = 2'b11,
      HD_RX   = 2'b10
   } hd_state_t;
endpackage

// >>> verilog/noise_if.sv
`timescale 1ns/1ps
interface noise_if;
   hdsc_pkg::pwr_t power;
   hdsc_pkg::pwr_t noise;
   logic [1:0]     rate;
   logic           tick;
   modport owner   (output power, output rate, output tick, input noise);
   modport tracker (input power, input rate, input tick, output noise);
endinterface

// >>> verilog/noise_floor_tracker.sv
`timescale 1ns/1ps
`include "hdsc_regs.svh"
module noise_floor_tracker (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // power and estimate
   noise_if.tracker nif
);
   logic [5:0] msCount;
   wire  [5:0] risePeriod;
   wire        riseDue;

   assign risePeriod = (nif.rate == 2'b00) ? `RISE_MS_3DB :
                       (nif.rate == 2'b01) ? `RISE_MS_6DB : `RISE_MS_12DB;
   assign riseDue    = nif.tick && (msCount >= risePeriod - 6'd1);

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         nif.noise <= '0;
         msCount   <= '0;
      end
      else if (nif.power <= nif.noise)
      begin
         nif.noise <= nif.power;
         msCount   <= '0;
      end
      else if (riseDue)
      begin
         nif.noise <= nif.noise + 10'd1;
         msCount   <= '0;
      end
      else if (nif.tick)
         msCount <= msCount + 6'd1;
   end

   chk_noise_drop: assert property (
      @(posedge clk) disable iff (!rstn)
      nif.power < nif.noise |=> nif.noise == $past(nif.power))
      else $error("noise estimate did not follow a drop");

   chk_noise_rise: assert property (
      @(posedge clk) disable iff (!rstn)
      nif.noise > $past(nif.noise) |->
      (nif.noise == $past(nif.noise) + 10'd1) && $past(nif.tick))
      else $error("noise estimate rose too fast");
endmodule

// >>> sim/halfduplex_suppression_control_bench.sv
`timescale 1ns/1ps
module halfduplex_suppression_control_bench;
   localparam int TK = 10;
   logic                clk;
   logic                rstn;
   logic [3:0]          addr;
   logic [15:0]         wdata;
   logic                wrStb;
   logic                rdStb;
   logic [15:0]         rdata;
   hdsc_pkg::pwr_t      rxPower;
   hdsc_pkg::pwr_t      txPower;
   logic                txSpeech;
   logic                rxEchoResidual;
   logic                doubleTalk;
   logic [2:0]          txDtAtt;
   logic [1:0]          rxDtAtt;
   logic                howlDetect;
   logic                retrainDone;
   logic                rxSpeech;
   logic                rxSuppress;
   hdsc_pkg::hd_state_t hdState;
   logic                fullDuplex;
   hdsc_pkg::att_t      txAtt;
   hdsc_pkg::att_t      rxAtt;
   hdsc_pkg::pwr_t      rxNoise;
   hdsc_pkg::pwr_t      txNoise;
   int                  failures;
   int                  samples_checked;

   halfduplex_suppression_control #(.TICK_CYCLES(TK)) u_halfduplex_suppression_control (
      .clk, .rstn, .addr, .wdata, .wrStb, .rdStb, .rdata, .rxPower, .txPower, .txSpeech,
      .rxEchoResidual, .doubleTalk, .txDtAtt, .rxDtAtt, .howlDetect, .retrainDone,
      .rxSpeech, .rxSuppress, .hdState, .fullDuplex, .txAtt, .rxAtt, .rxNoise, .txNoise);

   always #2 clk = ~clk;

   task automatic close_out();
      if (failures == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic timeout();
      failures++;
      close_out();
   endtask

   task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chkTime(input int t, input int lo, input int hi);
      samples_checked++;
      if (t < lo || t > hi)
      begin
         failures++;
         $display("[ERR] %0t got %h exp %h..%h", $time, t, lo, hi);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wrStb <= 1'b1;
      @(posedge clk);
      wrStb <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr  <= a;
      rdStb <= 1'b1;
      @(posedge clk);
      rdStb <= 1'b0;
      #1;
      chkVal(rdata, exp);
      cyc(1);
      chkVal(rdata, 16'h0000);
   endtask

   task automatic drvRx(input int v);
      @(posedge clk);
      rxPower <= 10'(v);
      cyc(3);
   endtask

   task automatic waitState(input hdsc_pkg::hd_state_t st, input int lim);
      int t;
      t = 0;
      while (hdState !== st)
      begin
         cyc(1);
         t++;
         if (t > lim)
            timeout();
      end
   endtask

   task automatic waitNoise(input hdsc_pkg::pwr_t v, input int lim, output int t);
      t = 0;
      while (rxNoise !== v)
      begin
         cyc(1);
         t++;
         if (t > lim)
            timeout();
      end
   endtask

   task automatic doReset();
      @(posedge clk);
      rstn <= 1'b0;
      cyc(20);
      chkVal(16'(rxSuppress), 16'h0001);
      chkVal(16'({fullDuplex, hdState, txAtt}), 16'h0000);
      @(posedge clk);
      rstn <= 1'b1;
      rd(4'h2, 16'h0004);
   endtask

   task automatic regTest();
      wr(4'h2, 16'h4024);
      rd(4'h2, 16'h4024);
      wr(4'h2, 16'hffe5);
      rd(4'h2, 16'h4024);
      wr(4'h3, 16'hffe4);
      rd(4'h2, 16'h4024);
      rd(4'h7, 16'h0000);
      wr(4'h2, 16'hffe4);
      rd(4'h2, 16'hffe4);
      wr(4'h2, 16'h0004);
   endtask

   task automatic speechThr(input logic [1:0] code, input int thr);
      wr(4'h2, {code, 14'h0004});
      drvRx(thr);
      chkVal(16'(rxSpeech), 16'h0000);
      drvRx(thr + 2);
      chkVal(16'(rxSpeech), 16'h0001);
      drvRx(0);
      chkVal(16'(rxNoise), 16'h0000);
   endtask

   task automatic relTest(input logic [1:0] code, input int thr);
      wr(4'h2, {2'b00, code, 12'h004});
      drvRx(thr);
      chkVal(16'({rxSpeech, rxSuppress}), 16'h0003);
      drvRx(thr + 2);
      chkVal(16'(rxSuppress), 16'h0000);
      drvRx(52);
      chkVal(16'(rxSuppress), 16'h0000);
      @(posedge clk);
      rxEchoResidual <= 1'b1;
      cyc(3);
      chkVal(16'(rxSuppress), 16'h0001);
      @(posedge clk);
      rxEchoResidual <= 1'b0;
      drvRx(0);
      chkVal(16'({rxSpeech, rxSuppress}), 16'h0001);
   endtask

   task automatic noiseRate(input logic [1:0] code, input int per);
      int t;
      wr(4'h2, {4'h0, code, 10'h004});
      @(posedge clk);
      rxPower <= 10'h003;
      txPower <= 10'h003;
      waitNoise(10'h001, per * TK + 5, t);
      waitNoise(10'h002, per * TK + 5, t);
      chkTime(t, per * TK - 2, per * TK + 2);
      cyc(2 * per * TK);
      chkVal(16'({rxNoise, txNoise}), 16'h0c03);
      @(posedge clk);
      rxPower <= 10'h000;
      txPower <= 10'h000;
      cyc(2);
      chkVal(16'({rxNoise, txNoise}), 16'h0000);
   endtask

   task automatic holdTest(input logic [1:0] code, input int ms);
      int t;
      wr(4'h2, {6'h00, code, 8'h04});
      @(posedge clk);
      rxPower <= 10'd100;
      waitState(hdsc_pkg::HD_RX, 20);
      @(posedge clk);
      rxPower  <= 10'h000;
      txSpeech <= 1'b1;
      waitState(hdsc_pkg::HD_HOLD, 20);
      t = 0;
      while (hdState === hdsc_pkg::HD_HOLD && t <= ms * TK + 2 * TK)
      begin
         cyc(1);
         t++;
      end
      chkTime(t, (ms - 1) * TK, ms * TK + 4);
      cyc(3);
      chkVal(16'(hdState), 16'(hdsc_pkg::HD_TX));
      @(posedge clk);
      txSpeech <= 1'b0;
      waitState(hdsc_pkg::HD_IDLE, ms * TK + 3 * TK);
   endtask

   task automatic howl(input logic hold);
      wr(4'h2, {8'h00, hold, 7'h04});
      @(posedge clk);
      howlDetect  <= 1'b1;
      retrainDone <= 1'b0;
      @(posedge clk);
      howlDetect <= 1'b0;
      #1;
      chkVal(16'(fullDuplex), 16'h0000);
      cyc(20);
      chkVal(16'(fullDuplex), 16'h0000);
      @(posedge clk);
      retrainDone <= 1'b1;
      cyc(20);
      chkVal(16'(fullDuplex), 16'(!hold));
      wr(4'h2, 16'h0004);
      cyc(5);
      chkVal(16'(fullDuplex), 16'h0001);
      @(posedge clk);
      howlDetect <= 1'b1;
      @(posedge clk);
      howlDetect <= 1'b0;
      #1;
      chkVal(16'(fullDuplex), 16'h0000);
      cyc(1);
      chkVal(16'(fullDuplex), 16'h0001);
   endtask

   task automatic rampTime(input int gt, input int gr, input int lim, output int tT,
                           output int tR);
      int t;
      t  = 0;
      tT = 0;
      tR = 0;
      while (tT == 0 || tR == 0)
      begin
         cyc(1);
         t++;
         if (tT == 0 && txAtt === 8'(gt))
            tT = t;
         if (tR == 0 && rxAtt === 8'(gr))
            tR = t;
         if (t > lim)
            timeout();
      end
   endtask

   task automatic ramp(input logic nt, input logic nr);
      int tT;
      int tR;
      int dt;
      int dr;
      wr(4'h2, {9'h000, nt, nr, 5'h04});
      @(posedge clk);
      txDtAtt    <= 3'h7;
      rxDtAtt    <= 2'h3;
      doubleTalk <= 1'b1;
      rampTime(168, 72, 50 * TK, tT, tR);
      chkTime(tT, 41 * TK, 42 * TK + 3);
      chkTime(tR, 17 * TK, 18 * TK + 3);
      @(posedge clk);
      doubleTalk <= 1'b0;
      dt = nt ? 84 : 1008;
      dr = nr ? 36 : 432;
      rampTime(0, 0, 1020 * TK, tT, tR);
      chkTime(tT, (dt - 6) * TK, dt * TK + 3);
      chkTime(tR, (dr - 6) * TK, dr * TK + 3);
   endtask

   initial
   begin
      failures = 0;
      samples_checked = 0;
      {clk, rstn, addr, wdata, wrStb, rdStb, rxPower, txPower} = '0;
      {txSpeech, rxEchoResidual, doubleTalk, txDtAtt, rxDtAtt, howlDetect, retrainDone} = '0;
      doReset();
      regTest();
      speechThr(2'b00, 48);
      speechThr(2'b01, 72);
      speechThr(2'b10, 96);
      speechThr(2'b11, 96);
      relTest(2'b01, 72);
      relTest(2'b10, 96);
      relTest(2'b11, 96);
      noiseRate(2'b00, 42);
      noiseRate(2'b01, 21);
      noiseRate(2'b10, 10);
      holdTest(2'b00, 200);
      holdTest(2'b01, 100);
      holdTest(2'b10, 150);
      holdTest(2'b11, 150);
      wr(4'h2, 16'h0014);
      cyc(4);
      chkVal(16'(hdState), 16'(hdsc_pkg::HD_TX));
      doReset();
      @(posedge clk);
      retrainDone <= 1'b1;
      cyc(5);
      howl(1'b0);
      howl(1'b1);
      ramp(1'b1, 1'b1);
      ramp(1'b0, 1'b0);
      close_out();
   end
endmodule
